// >>> eiob_bridge.sv
`timescale 1ns/100ps
`include "eiob_defs.svh"

// Functional notes
// - controller port registers decode into external data space at base 0xFD00
// - window holds eight 16-bit registers, offsets 0x0 to 0xE, two bytes each
// - 8-bit mode: no interrupts, no DMA, no serial configuration memory; polling only
// - controller grants transmit only when buffer memory holds the whole frame
// - controller defers until medium free and retransmits after a collision
module eiob_bridge (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_rd_n,
    input  wire logic        cpu_wr_n,
    input  wire logic [7:0]  cpu_din,
    output logic      [7:0]  cpu_dout,
    output logic             cpu_doe,
    output logic             cpu_wait,
    output logic             eth_cs_n,
    output logic             eth_rd_n,
    output logic             eth_wr_n,
    output logic      [3:0]  eth_addr,
    input  wire logic [7:0]  eth_din,
    output logic      [7:0]  eth_dout,
    output logic             eth_oe,
    output logic             eth_byte_high_en_n,
    output logic             eth_dma_ack_n,
    output logic             eth_eeprom_sel,
    output logic      [15:0] indirect_address_reg
);
    localparam int ACC_I = `EIOB_ACCESS_CYC;

    eiob_pkg::eiob_regs_s r;
    eiob_pkg::eiob_regs_s next_r;
    logic                 hit;
    logic                 wr_fall;
    logic                 rd_fall;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic                 fifo_out_ready;
    logic [11:0]          fifo_out_data;
    eiob_pkg::eiob_req_s  fifo_head;

    // decode looks only at second-stage copies of the pin inputs
    assign hit       = (r.addr_s2[15:4] == `EIOB_BASE_HI);
    assign wr_fall   = r.wr_prev && !r.wr_s2;
    assign rd_fall   = r.rd_prev && !r.rd_s2;
    assign fifo_head = fifo_out_data;

    // writes are posted into the queue so the processor is held only until the queue takes each byte
    eiob_fifo #(
        .WIDTH (`EIOB_FIFO_WIDTH),
        .DEPTH (`EIOB_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (r.wr_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (r.wr_req),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // next-state logic: synchronisers, capture of processor cycles, controller sequencer
    always_comb
    begin
        next_r         = r;
        fifo_out_ready = 1'b0;
        next_r.rd_s1   = cpu_rd_n;
        next_r.rd_s2   = r.rd_s1;
        next_r.rd_prev = r.rd_s2;
        next_r.wr_s1   = cpu_wr_n;
        next_r.wr_s2   = r.wr_s1;
        next_r.wr_prev = r.wr_s2;
        next_r.addr_s1 = cpu_addr;
        next_r.addr_s2 = r.addr_s1;
        next_r.din_s1  = cpu_din;
        next_r.din_s2  = r.din_s1;
        next_r.edin_s1 = eth_din;
        next_r.edin_s2 = r.edin_s1;

        // queue accepted the posted write
        if (r.wr_pend && fifo_in_ready)
        begin
            next_r.wr_pend = 1'b0;
        end

        // processor write inside the window; outside it nothing is started
        if (wr_fall && hit)
        begin
            next_r.wr_pend     = 1'b1;
            next_r.wr_req.off  = r.addr_s2[3:0];
            next_r.wr_req.data = r.din_s2;
            // shadow of the indirect address, low byte then high byte
            if (r.addr_s2[3:0] == `EIOB_OFF_PTR_LO)
            begin
                next_r.ptr_shadow[7:0] = r.din_s2;
            end
            if (r.addr_s2[3:0] == `EIOB_OFF_PTR_HI)
            begin
                next_r.ptr_shadow[15:8] = r.din_s2;
            end
        end

        // processor read inside the window is held until the data returns
        if (rd_fall && hit)
        begin
            next_r.rd_pend = 1'b1;
            next_r.rd_off  = r.addr_s2[3:0];
        end

        // data bus released once the synchronised read strobe is seen high again
        if (r.rd_s2)
        begin
            next_r.cpu_doe = 1'b0;
        end

        // controller sequencer; no timeout, transmit status is only polled
        case (r.st)
            eiob_pkg::ST_IDLE:
            begin
                next_r.cnt = '0;
                // queued writes drain before any read so a poll sees every prior write
                if (fifo_out_valid)
                begin
                    fifo_out_ready  = 1'b1;
                    next_r.eth_addr = fifo_head.off;
                    next_r.eth_dout = fifo_head.data;
                    next_r.eth_oe   = 1'b1;
                    next_r.eth_cs_n = 1'b0;
                    next_r.eth_wr_n = 1'b0;
                    next_r.st       = eiob_pkg::ST_WRITE;
                end
                else if (r.rd_pend && !r.wr_pend)
                begin
                    next_r.eth_addr = r.rd_off;
                    next_r.eth_cs_n = 1'b0;
                    next_r.eth_rd_n = 1'b0;
                    next_r.st       = eiob_pkg::ST_READ;
                end
            end
            eiob_pkg::ST_WRITE:
            begin
                next_r.cnt = r.cnt + 6'h01;
                if (r.cnt == 6'(`EIOB_ACCESS_CYC - 1))
                begin
                    next_r.eth_wr_n = 1'b1;
                    next_r.eth_cs_n = 1'b1;
                    next_r.cnt      = '0;
                    next_r.st       = eiob_pkg::ST_RECOVER;
                end
            end
            eiob_pkg::ST_READ:
            begin
                next_r.cnt = r.cnt + 6'h01;
                // the synchronised data has settled well before the strobe ends
                if (r.cnt == 6'(`EIOB_ACCESS_CYC - 1))
                begin
                    next_r.rd_data  = r.edin_s2;
                    next_r.eth_rd_n = 1'b1;
                    next_r.eth_cs_n = 1'b1;
                    // a read falling on this very edge stays pending, the set wins
                    next_r.rd_pend  = rd_fall && hit;
                    next_r.cpu_doe  = !r.rd_s2;
                    next_r.cnt      = '0;
                    next_r.st       = eiob_pkg::ST_RECOVER;
                end
            end
            eiob_pkg::ST_RECOVER:
            begin
                // data held one cycle past the write strobe for hold time
                next_r.eth_oe = 1'b0;
                next_r.cnt    = r.cnt + 6'h01;
                if (r.cnt == 6'(`EIOB_RECOVER_CYC - 1))
                begin
                    next_r.cnt = '0;
                    next_r.st  = eiob_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_r.st = eiob_pkg::ST_IDLE;
            end
        endcase
    end

    // state register; strobes idle high after reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r            <= '0;
            r.rd_s1      <= 1'b1;
            r.rd_s2      <= 1'b1;
            r.rd_prev    <= 1'b1;
            r.wr_s1      <= 1'b1;
            r.wr_s2      <= 1'b1;
            r.wr_prev    <= 1'b1;
            r.eth_cs_n   <= 1'b1;
            r.eth_rd_n   <= 1'b1;
            r.eth_wr_n   <= 1'b1;
            r.st         <= eiob_pkg::ST_IDLE;
            r.ptr_shadow <= `EIOB_PTR_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs; wait is a level so the processor stretches until done
    assign cpu_dout             = r.rd_data;
    assign cpu_doe              = r.cpu_doe;
    assign cpu_wait             = r.wr_pend || r.rd_pend;
    assign eth_cs_n             = r.eth_cs_n;
    assign eth_rd_n             = r.eth_rd_n;
    assign eth_wr_n             = r.eth_wr_n;
    assign eth_addr             = r.eth_addr;
    assign eth_dout             = r.eth_dout;
    assign eth_oe               = r.eth_oe;
    assign indirect_address_reg = r.ptr_shadow;

    // 8-bit port mode: high byte, dma and config memory stay idle
    assign eth_byte_high_en_n   = 1'b1;
    assign eth_dma_ack_n        = 1'b1;
    assign eth_eeprom_sel       = 1'b0;

    // checks run on the system clock and stay quiet while reset is held
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // shape of one controller cycle
    a_strobe_length: assert property ($fell(eth_cs_n) |-> ##[ACC_I:ACC_I] $rose(eth_cs_n))
        else $error("controller access not of the set length");
    a_strobe_in_cs: assert property ((!eth_rd_n || !eth_wr_n) |-> !eth_cs_n)
        else $error("strobe outside chip access");
    a_one_strobe_only: assert property (!(!eth_rd_n && !eth_wr_n))
        else $error("read and write strobes together");
    a_window_miss_ignored: assert property ((wr_fall && !hit && !r.wr_pend) |=> !r.wr_pend)
        else $error("write outside window was queued");
    a_write_queued_offset: assert property ((wr_fall && hit)
        |=> r.wr_pend && r.wr_req.off == $past(r.addr_s2[3:0]))
        else $error("window write not queued with its offset");
    a_ptr_low_byte: assert property ((wr_fall && hit && r.addr_s2[3:0] == `EIOB_OFF_PTR_LO)
        |=> indirect_address_reg[7:0] == $past(r.din_s2))
        else $error("indirect address low byte not captured");
    a_read_after_drain: assert property ($fell(eth_rd_n) |-> $past(!fifo_out_valid))
        else $error("read issued ahead of queued writes");
    a_read_data_capture: assert property ($rose(eth_rd_n) |=> cpu_dout == $past(r.edin_s2, 2))
        else $error("read data not captured at strobe end");
    a_write_data_driven: assert property (!eth_wr_n |-> eth_oe)
        else $error("write strobe without data drive");
    a_wait_on_read: assert property ((rd_fall && hit) |=> cpu_wait [*2])
        else $error("processor not held during read");

    // pointer high byte lands in the shadow just like the low byte
    a_ptr_high_byte: assert property ((wr_fall && hit && r.addr_s2[3:0] == `EIOB_OFF_PTR_HI)
        |=> indirect_address_reg[15:8] == $past(r.din_s2))
        else $error("indirect address high byte not captured");
    a_read_miss_ignored: assert property ((rd_fall && !hit && !r.rd_pend) |=> !r.rd_pend)
        else $error("read outside window was taken");

    // offset handed to the controller is the one the processor used
    a_write_offset_passed: assert property ($fell(eth_wr_n) |-> eth_addr == $past(fifo_head.off))
        else $error("write offset not passed to controller");
    a_read_offset_passed: assert property ($fell(eth_rd_n) |-> eth_addr == $past(r.rd_off))
        else $error("read offset not passed to controller");

    // address and data may not move under a strobe, the controller latches late
    a_addr_held_access: assert property ((!eth_cs_n && !$fell(eth_cs_n)) |-> $stable(eth_addr))
        else $error("controller address moved during access");
    a_write_data_held: assert property ((!eth_wr_n && !$fell(eth_wr_n)) |-> $stable(eth_dout))
        else $error("write data moved during strobe");
    a_no_drive_read: assert property (eth_oe |-> eth_rd_n)
        else $error("bridge drives controller bus during a read");
    a_recovery_gap: assert property ($rose(eth_cs_n) |=> eth_cs_n [*8])
        else $error("controller access started inside recovery");
    a_idle_no_access: assert property ((r.st == eiob_pkg::ST_IDLE) |-> eth_cs_n)
        else $error("chip access while sequencer idle");

    // processor data bus driven only for a finished window read, and let go promptly
    a_doe_only_reads: assert property ($rose(cpu_doe) |-> $rose(eth_rd_n))
        else $error("processor bus driven without a read");
    a_doe_release: assert property (r.rd_s2 |=> !cpu_doe)
        else $error("processor bus held after read strobe");
    a_full_queue_holds: assert property ((r.wr_pend && !fifo_in_ready) |=> r.wr_pend)
        else $error("posted write dropped while queue full");

    // main scenarios seen at least once
    c_write_cycle: cover property ($rose(eth_wr_n));
    c_read_cycle: cover property ($rose(eth_rd_n) ##1 cpu_doe);
    c_queue_full: cover property (r.wr_pend && !fifo_in_ready);
    c_window_miss: cover property (wr_fall && !hit);
    c_pointer_load: cover property (wr_fall && hit && r.addr_s2[3:0] == `EIOB_OFF_PTR_HI);

endmodule

// >>> eiob_ctrl_model.sv
`timescale 1ns/100ps

// controller in 8-bit port mode: serviced by polling only, so no interrupt,
// dma or serial memory side is modelled
module eiob_ctrl_model (
    input  wire logic       sys_clk,
    input  wire logic       eth_cs_n,
    input  wire logic       eth_rd_n,
    input  wire logic       eth_wr_n,
    input  wire logic [3:0] eth_addr,
    input  wire logic [7:0] eth_dout,
    input  wire logic       eth_oe,
    output logic      [7:0] eth_din
);
    logic [7:0]  port_b [16];
    logic [15:0] mem [256];
    logic        w_pend = 1'b0;
    logic [3:0]  w_off;
    logic [7:0]  w_dat;
    logic [7:0]  ptr;

    assign ptr = port_b[4'hA];

    initial
    begin
        eth_din = 8'h5A;
        foreach (port_b[i]) port_b[i] = 8'h00;
        foreach (mem[i]) mem[i] = 16'h0000;
    end

    // indirect data bytes go through the pointer, all others are plain ports
    function automatic logic [7:0] rd_byte(input logic [3:0] off);
        if (off == 4'hC) return mem[ptr][7:0];
        if (off == 4'hD) return mem[ptr][15:8];
        return port_b[off];
    endfunction

    // a write is taken during the strobe and lands when chip access ends
    always @(posedge sys_clk)
    begin
        if (!eth_cs_n && !eth_wr_n && eth_oe)
        begin
            w_pend <= 1'b1;
            w_off <= eth_addr;
            w_dat <= eth_dout;
        end
        else if (eth_cs_n && w_pend)
        begin
            w_pend <= 1'b0;
            if (w_off == 4'hC) mem[ptr][7:0] <= w_dat;
            else if (w_off == 4'hD) mem[ptr][15:8] <= w_dat;
            else port_b[w_off] <= w_dat;
        end
    end

    // a released bus flips every cycle so stale bytes never pass as data
    always @(posedge sys_clk)
        eth_din <= (!eth_cs_n && !eth_rd_n) ? rd_byte(eth_addr) : ~eth_din;
endmodule

// >>> eiob_defs.svh
`ifndef EIOB_DEFS_SVH
`define EIOB_DEFS_SVH

// window placement: upper twelve address bits select the port block
`define EIOB_BASE_HI       12'hFD0
`define EIOB_BASE_ADDR     16'hFD00
`define EIOB_LAST_REG      16'hFD0E

// byte offsets inside the window
`define EIOB_OFF_PTR_LO    4'hA
`define EIOB_OFF_PTR_HI    4'hB
`define EIOB_OFF_DATA_LO   4'hC
`define EIOB_OFF_DATA_HI   4'hD

// reset values
`define EIOB_PTR_RESET     16'h0000

// controller bus timing, least times, rounded up to whole clocks
`define EIOB_CLK_NS        5
`define EIOB_ACCESS_NS     120
`define EIOB_RECOVER_NS    40
`define EIOB_ACCESS_CYC    ((`EIOB_ACCESS_NS + `EIOB_CLK_NS - 1) / `EIOB_CLK_NS)
`define EIOB_RECOVER_CYC   ((`EIOB_RECOVER_NS + `EIOB_CLK_NS - 1) / `EIOB_CLK_NS)

// write queue shape
`define EIOB_FIFO_DEPTH    32
`define EIOB_FIFO_WIDTH    12

`endif

// >>> eiob_fifo.sv
`timescale 1ns/100ps
`include "eiob_defs.svh"

module eiob_fifo #(
    parameter int WIDTH = `EIOB_FIFO_WIDTH,
    parameter int DEPTH = `EIOB_FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } eiob_fifo_s;

    eiob_fifo_s           r;
    eiob_fifo_s           next_r;
    logic [WIDTH-1:0]     mem [DEPTH];
    logic                 full;
    logic                 empty;

    // extra pointer bit tells a full queue from an empty one
    assign full      = (r.wptr[AW] != r.rptr[AW]) && (r.wptr[AW-1:0] == r.rptr[AW-1:0]);
    assign empty     = (r.wptr == r.rptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[r.rptr[AW-1:0]];

    // pointer update
    always_comb
    begin
        next_r = r;
        if (in_valid && !full)
        begin
            next_r.wptr = r.wptr + 1'b1;
        end
        if (out_ready && !empty)
        begin
            next_r.rptr = r.rptr + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // storage has no reset, only written entries are ever read
    always_ff @(posedge sys_clk)
    begin
        if (in_valid && !full)
        begin
            mem[r.wptr[AW-1:0]] <= in_data;
        end
    end

endmodule

// >>> eiob_pkg.sv
package eiob_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_RECOVER} eiob_state_e;

    // one queued byte write toward the controller
    typedef struct packed {
        logic [3:0] off;
        logic [7:0] data;
    } eiob_req_s;

    // complete state of the bridge
    typedef struct packed {
        logic              rd_s1;
        logic              rd_s2;
        logic              rd_prev;
        logic              wr_s1;
        logic              wr_s2;
        logic              wr_prev;
        logic [15:0]       addr_s1;
        logic [15:0]       addr_s2;
        logic [7:0]        din_s1;
        logic [7:0]        din_s2;
        logic [7:0]        edin_s1;
        logic [7:0]        edin_s2;
        logic              wr_pend;
        eiob_req_s         wr_req;
        logic              rd_pend;
        logic [3:0]        rd_off;
        logic [7:0]        rd_data;
        logic              cpu_doe;
        eiob_state_e       st;
        logic [5:0]        cnt;
        logic              eth_cs_n;
        logic              eth_rd_n;
        logic              eth_wr_n;
        logic [3:0]        eth_addr;
        logic [7:0]        eth_dout;
        logic              eth_oe;
        logic [15:0]       ptr_shadow;
    } eiob_regs_s;

endpackage

// >>> tb.sv
`timescale 1ns/100ps

module tb;
    logic        sys_clk;
    logic        rst_n;
    logic [15:0] cpu_addr;
    logic        cpu_rd_n;
    logic        cpu_wr_n;
    logic [7:0]  cpu_din;
    logic [7:0]  cpu_dout;
    logic        cpu_doe;
    logic        cpu_wait;
    logic        eth_cs_n;
    logic        eth_rd_n;
    logic        eth_wr_n;
    logic [3:0]  eth_addr;
    logic [7:0]  eth_din;
    logic [7:0]  eth_dout;
    logic        eth_oe;
    logic        eth_byte_high_en_n;
    logic        eth_dma_ack_n;
    logic        eth_eeprom_sel;
    logic [15:0] indirect_address_reg;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          stall_max = 0;
    logic [31:0] rng = 32'h70A9;
    logic [7:0]  ref_b [16];
    logic [15:0] ref_m [256];
    logic [4:0]  exp_q [$];
    logic        cs_prev = 1'b1;
    logic [7:0]  rd_val;
    logic [15:0] ptrs [6];
    logic [15:0] outs [4] = '{16'hFCFF, 16'hFD10, 16'hED00, 16'h0D0C};

    eiob_bridge dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_rd_n(cpu_rd_n),
        .cpu_wr_n(cpu_wr_n), .cpu_din(cpu_din), .cpu_dout(cpu_dout), .cpu_doe(cpu_doe),
        .cpu_wait(cpu_wait), .eth_cs_n(eth_cs_n), .eth_rd_n(eth_rd_n), .eth_wr_n(eth_wr_n),
        .eth_addr(eth_addr), .eth_din(eth_din), .eth_dout(eth_dout), .eth_oe(eth_oe),
        .eth_byte_high_en_n(eth_byte_high_en_n), .eth_dma_ack_n(eth_dma_ack_n),
        .eth_eeprom_sel(eth_eeprom_sel), .indirect_address_reg(indirect_address_reg));

    eiob_ctrl_model ctrl_u (
        .sys_clk(sys_clk), .eth_cs_n(eth_cs_n), .eth_rd_n(eth_rd_n), .eth_wr_n(eth_wr_n),
        .eth_addr(eth_addr), .eth_dout(eth_dout), .eth_oe(eth_oe), .eth_din(eth_din));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one processor cycle, strobe held until wait falls; reference updated alongside
    task automatic cpu_cyc(input logic rd, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        logic hit;
        logic [3:0] o;
        logic [7:0] e;
        hit = (a[15:4] == 12'hFD0);
        o = a[3:0];
        n = 0;
        if (hit) exp_q.push_back({rd, o});
        e = (o == 4'hC) ? ref_m[ref_b[10]][7:0] : (o == 4'hD) ? ref_m[ref_b[10]][15:8] : ref_b[o];
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_din <= d;
        if (rd) cpu_rd_n <= 1'b0;
        else cpu_wr_n <= 1'b0;
        repeat (8) @(negedge sys_clk) n += int'(cpu_wait);
        chk(16'(n > 0), 16'(hit));
        n = 0;
        while (cpu_wait === 1'b1 && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
        q = cpu_dout;
        if (!rd && n > stall_max) stall_max = n;
        if (rd) chk(16'(cpu_doe), 16'(hit));
        if (rd && hit) chk(16'(q), 16'(e));
        if (hit && !rd && o == 4'hC) ref_m[ref_b[10]][7:0] = d;
        else if (hit && !rd && o == 4'hD) ref_m[ref_b[10]][15:8] = d;
        else if (hit && !rd) ref_b[o] = d;
        @(posedge sys_clk);
        cpu_rd_n <= 1'b1;
        cpu_wr_n <= 1'b1;
        repeat (6) @(negedge sys_clk);
        chk(16'(cpu_doe), 16'h0000);
    endtask

    // each chip access must match the next queued processor cycle in kind and offset
    always @(negedge sys_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            miscompares++;
            close_out();
        end
        if (cs_prev && !eth_cs_n)
            chk({11'h0, !eth_rd_n, eth_addr}, {11'h0, exp_q.size() > 0 ? exp_q.pop_front() : 5'h1F});
        cs_prev <= eth_cs_n;
    end

    initial
    begin
        rst_n = 1'b0;
        cpu_addr = 16'h0000;
        cpu_rd_n = 1'b1;
        cpu_wr_n = 1'b1;
        cpu_din = 8'h00;
        foreach (ref_b[i]) ref_b[i] = 8'h00;
        foreach (ref_m[i]) ref_m[i] = 16'h0000;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk({12'h000, eth_byte_high_en_n, eth_dma_ack_n, eth_eeprom_sel, eth_cs_n}, 16'h000D);
        // direct port bytes, up to the top of the window
        for (int o = 0; o < 16; o++)
        begin
            rng = xs(rng);
            if (o < 10 || o > 13) cpu_cyc(1'b0, 16'hFD00 + 16'(o), rng[7:0], rd_val);
        end
        for (int o = 0; o < 16; o++)
            if (o < 10 || o > 13) cpu_cyc(1'b1, 16'hFD00 + 16'(o), 8'h00, rd_val);
        // indirect writes, pointer low byte first, then data
        foreach (ptrs[k])
        begin
            rng = xs(rng);
            ptrs[k] = rng[15:0];
            cpu_cyc(1'b0, 16'hFD0A, rng[7:0], rd_val);
            cpu_cyc(1'b0, 16'hFD0B, rng[15:8], rd_val);
            cpu_cyc(1'b0, 16'hFD0C, rng[23:16], rd_val);
            cpu_cyc(1'b0, 16'hFD0D, rng[31:24], rd_val);
        end
        // reload each pointer and read back high byte then low byte
        foreach (ptrs[k])
        begin
            cpu_cyc(1'b0, 16'hFD0A, ptrs[k][7:0], rd_val);
            cpu_cyc(1'b0, 16'hFD0B, ptrs[k][15:8], rd_val);
            cpu_cyc(1'b1, 16'hFD0D, 8'h00, rd_val);
            cpu_cyc(1'b1, 16'hFD0C, 8'h00, rd_val);
            chk(indirect_address_reg, ptrs[k]);
        end
        cpu_cyc(1'b1, 16'hFD0B, 8'h00, rd_val);
        // neighbours of the window must never reach the controller
        foreach (outs[k])
        begin
            cpu_cyc(1'b0, outs[k], 8'hA5, rd_val);
            cpu_cyc(1'b1, outs[k], 8'h00, rd_val);
        end
        // posted writes outrun the controller until the queue refuses
        stall_max = 0;
        for (int k = 0; k < 90; k++)
        begin
            rng = xs(rng);
            cpu_cyc(1'b0, 16'hFD0E, rng[7:0], rd_val);
        end
        chk(16'(stall_max > 8), 16'h0001);
        // frame bytes copied in, now poll the controller the way a host waits for transmit
        cpu_cyc(1'b1, 16'hFD0E, 8'h00, rd_val);
        chk(16'(exp_q.size()), 16'h0000);
        chk({12'h000, eth_byte_high_en_n, eth_dma_ack_n, eth_eeprom_sel, eth_cs_n}, 16'h000D);
        close_out();
    end
endmodule
